// File: data_flash_command_sequencer.sv
// Command sequencer for the 640-byte data flash array
`timescale 1ns/1ps
module data_flash_command_sequencer import flash_seq_pkg::*; #(
  parameter int ERASE_COUNT = ERASE_CYCLES,
  parameter int PROGRAM_COUNT = PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  output logic core_hold,
  output logic irq_block
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_READ, ST_VERIFY, ST_PROG, ST_ERASE, ST_WAIT
  } state_t;
  state_t state_r, state_nxt;
  logic [7:0] command_r, command_nxt;
  logic [7:0] page_r, page_nxt;
  page_t data_r, data_nxt;
  logic [7:0] sweep_r, sweep_nxt;
  logic [TIMER_BITS-1:0] timer_r, timer_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic erase_all_r, erase_all_nxt;
  logic mem_we;
  logic [7:0] mem_addr;
  page_t mem_wdata;
  page_t mem_rdata;
  logic cmd_write;
  logic page_ok;
  assign cmd_write = sfr_req.wr && sfr_req.addr == ADDR_COMMAND;
  assign page_ok = page_r <= LAST_PAGE;
  page_array #(.PAGES(PAGE_COUNT)) u_array (
    .clock(clock),
    .clk_en(clk_en),
    .addr(mem_addr),
    .wr_en(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );
  // ==========================================================
  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    command_nxt = command_r;
    page_nxt = page_r;
    data_nxt = data_r;
    sweep_nxt = sweep_r;
    timer_nxt = timer_r;
    erase_all_nxt = erase_all_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    mem_we = 1'b0;
    mem_addr = erase_all_r ? sweep_r : page_r;
    mem_wdata = {4{ERASED_BYTE}};
    if (sfr_req.rd) begin
      rvalid_nxt = 1'b1;
      case (sfr_req.addr)
        ADDR_COMMAND: rdata_nxt = command_r;
        ADDR_PAGE: rdata_nxt = page_r;
        8'hBC: rdata_nxt = data_r[7:0];
        8'hBD: rdata_nxt = data_r[15:8];
        8'hBE: rdata_nxt = data_r[23:16];
        8'hBF: rdata_nxt = data_r[31:24];
        default: rdata_nxt = 8'h00;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        if (sfr_req.wr && state_r == ST_IDLE) begin
          case (sfr_req.addr)
            ADDR_PAGE: page_nxt = sfr_req.wdata;
            8'hBC: data_nxt[7:0] = sfr_req.wdata;
            8'hBD: data_nxt[15:8] = sfr_req.wdata;
            8'hBE: data_nxt[23:16] = sfr_req.wdata;
            8'hBF: data_nxt[31:24] = sfr_req.wdata;
            default: ;
          endcase
        end
        if (cmd_write) begin
          command_nxt = sfr_req.wdata;
          erase_all_nxt = 1'b0;
          sweep_nxt = 8'h00;
          // Operation starts on the write itself
          case (sfr_req.wdata)
            CMD_READ, CMD_VERIFY: state_nxt = page_ok ? ST_FETCH : ST_IDLE;
            CMD_PROGRAM: begin
              state_nxt = page_ok ? ST_PROG : ST_IDLE;
              timer_nxt = TIMER_BITS'(PROGRAM_COUNT - 1);
            end
            CMD_ERASE_PAGE: begin
              state_nxt = page_ok ? ST_ERASE : ST_IDLE;
              timer_nxt = TIMER_BITS'(ERASE_COUNT - 1);
            end
            CMD_ERASE_ALL: begin
              state_nxt = ST_ERASE;
              erase_all_nxt = 1'b1;
              timer_nxt = TIMER_BITS'(ERASE_COUNT - 1);
            end
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_FETCH: begin
        state_nxt = (command_r == CMD_READ) ? ST_READ : ST_VERIFY;
      end
      ST_READ: begin
        data_nxt = mem_rdata;
        state_nxt = ST_IDLE;
      end
      ST_VERIFY: begin
        command_nxt = (mem_rdata == data_r) ? 8'h00 : VERIFY_FAIL;
        state_nxt = ST_IDLE;
      end
      ST_PROG: begin
        if (timer_r == '0) begin
          mem_we = 1'b1;
          mem_wdata = data_r;
          state_nxt = ST_IDLE;
        end else begin
          timer_nxt = timer_r - 1'b1;
        end
      end
      ST_ERASE: begin
        // Whole pages set to erased value
        if (erase_all_r) begin
          if (sweep_r <= LAST_PAGE) begin
            mem_we = 1'b1;
            sweep_nxt = sweep_r + 8'h01;
          end
        end else if (sweep_r == 8'h00) begin
          mem_we = 1'b1;
          sweep_nxt = 8'h01;
        end
        if (timer_r == '0) begin
          state_nxt = ST_WAIT;
        end else begin
          timer_nxt = timer_r - 1'b1;
        end
      end
      ST_WAIT: begin
        erase_all_nxt = 1'b0;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // ==========================================================
  // State registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      command_r <= RESET_COMMAND;
      page_r <= RESET_PAGE;
      data_r <= {4{RESET_DATA}};
      sweep_r <= 8'h00;
      timer_r <= '0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      erase_all_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      command_r <= command_nxt;
      page_r <= page_nxt;
      data_r <= data_nxt;
      sweep_r <= sweep_nxt;
      timer_r <= timer_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      erase_all_r <= erase_all_nxt;
    end
  end
  // ==========================================================
  // Outputs
  assign sfr_rdata = rdata_r;
  assign sfr_rvalid = rvalid_r;
  assign core_hold = (state_r != ST_IDLE) || cmd_write;
  assign irq_block = core_hold;
  // ==========================================================
  // Assertions
  a_hold_busy: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r != ST_IDLE |-> core_hold)
    else $error("core not held while busy");
  a_read_done: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r == ST_IDLE && cmd_write && sfr_req.wdata == CMD_READ
    && page_ok ##1 clk_en [*2] |=> state_r == ST_IDLE)
    else $error("read took too long");
  a_irq_busy: assert property (
    @(posedge clock) disable iff (sys_rst)
    irq_block == core_hold)
    else $error("interrupt block differs from hold");
  a_bad_page: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r == ST_IDLE && cmd_write && !page_ok
    |=> state_r == ST_IDLE)
    else $error("bad page started operation");
  a_start_now: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r == ST_IDLE && cmd_write && page_ok
    && sfr_req.wdata == CMD_PROGRAM |=> state_r == ST_PROG)
    else $error("program did not start");
  a_prog_write: assert property (
    @(posedge clock) disable iff (sys_rst)
    mem_we && state_r == ST_PROG |-> mem_wdata == data_r)
    else $error("program wrote wrong data");
  a_erase_data: assert property (
    @(posedge clock) disable iff (sys_rst)
    mem_we && state_r == ST_ERASE |-> mem_wdata == {4{ERASED_BYTE}})
    else $error("erase wrote non-erased value");
  a_verify_res: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r == ST_VERIFY |=> (command_r == 8'h00) ==
    ($past(mem_rdata) == $past(data_r)))
    else $error("verify result wrong");
  a_page_range: assert property (
    @(posedge clock) disable iff (sys_rst)
    mem_we |-> mem_addr <= LAST_PAGE)
    else $error("array write outside valid pages");
  a_sweep_all: assert property (
    @(posedge clock) disable iff (sys_rst)
    state_r == ST_WAIT && erase_all_r |-> sweep_r == LAST_PAGE + 8'h01)
    else $error("erase all missed pages");
  a_busy_page: assert property (
    @(posedge clock) disable iff (sys_rst)
    clk_en && state_r != ST_IDLE |=> page_r == $past(page_r))
    else $error("page address changed while busy");
  c_read: cover property (@(posedge clock) state_r == ST_READ);
  c_verify: cover property (@(posedge clock) state_r == ST_VERIFY);
  c_prog: cover property (@(posedge clock) state_r == ST_PROG && mem_we);
  c_erase_all: cover property (@(posedge clock) erase_all_r && mem_we);
  c_erase_page: cover property (@(posedge clock)
    state_r == ST_WAIT && !erase_all_r);
endmodule // data_flash_command_sequencer

// File: flash_seq_pkg.sv
// Package of constants and types for the data flash command sequencer
package flash_seq_pkg;
  // ==========================================================
  // Register addresses and reset values
  localparam logic [7:0] ADDR_COMMAND = 8'hB9;
  localparam logic [7:0] ADDR_PAGE = 8'hC6;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'hBC;
  localparam logic [7:0] ADDR_DATA_LAST = 8'hBF;
  localparam logic [7:0] RESET_COMMAND = 8'h00;
  localparam logic [7:0] RESET_PAGE = 8'h00;
  localparam logic [7:0] RESET_DATA = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] VERIFY_FAIL = 8'h01;
  // ==========================================================
  // Commands
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  // ==========================================================
  // Array geometry
  localparam int PAGE_COUNT = 160;
  localparam logic [7:0] LAST_PAGE = 8'h9F;
  // ==========================================================
  // Timing
  localparam int CLOCK_MHZ = 250;
  localparam int ERASE_TIME_US = 2000;
  localparam int PROGRAM_TIME_US = 250;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLOCK_MHZ;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int TIMER_BITS = 20;
  // ==========================================================
  // Bus carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef logic [31:0] page_t;
endpackage

// File: page_array.sv
// Page memory of the data flash array with registered read data
`timescale 1ns/1ps
module page_array import flash_seq_pkg::*; #(
  parameter int PAGES = PAGE_COUNT
) (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic [7:0] addr,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [PAGES];
  // ==========================================================
  // Array starts erased
  initial begin
    for (int i = 0; i < PAGES; i++) begin
      mem[i] = {4{ERASED_BYTE}};
    end
  end
  always @(posedge clock) begin
    if (clk_en) begin
      if (wr_en && addr < 8'(PAGES)) begin
        mem[addr] <= wdata;
      end
      rdata <= (addr < 8'(PAGES)) ? mem[addr] : {4{ERASED_BYTE}};
    end
  end
endmodule // page_array

// File: sfr_core_model.sv
// Core-side model that drives the special function register bus
`timescale 1ns/1ps
module sfr_core_model import flash_seq_pkg::*; (
  input wire logic clock,
  input wire logic core_hold,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  output sfr_req_t sfr_req
);
  logic hang = 1'b0;
  initial begin
    sfr_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  end
  // ==========================================================
  // One strobe cycle, released bus shows inverted leftovers
  task automatic bus_cycle(input logic rd, input logic [7:0] addr,
      input logic [7:0] wdata);
    int n;
    n = 0;
    while (core_hold === 1'b1 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    if (n == 2000) begin
      hang = 1'b1;
    end
    @(posedge clock);
    sfr_req <= '{wr: !rd, rd: rd, addr: addr, wdata: wdata};
    @(posedge clock);
    sfr_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
      output logic valid);
    bus_cycle(1'b1, addr, 8'h00);
    #1;
    data = sfr_rdata;
    valid = sfr_rvalid;
  endtask
  // ==========================================================
  // Page address first, data only when asked, command last
  task automatic page_op(input logic [7:0] page, input logic load,
      input page_t data, input logic [7:0] cmd);
    bus_cycle(1'b0, ADDR_PAGE, page);
    if (load) begin
      for (int i = 0; i < 4; i++) begin
        bus_cycle(1'b0, ADDR_DATA_FIRST + 8'(i), data[8*i +: 8]);
      end
    end
    bus_cycle(1'b0, ADDR_COMMAND, cmd);
  endtask
endmodule // sfr_core_model

// File: data_flash_command_sequencer_tb.sv
// Self-checking testbench for the data flash command sequencer
`timescale 1ns/1ps
module data_flash_command_sequencer_tb import flash_seq_pkg::*;;
  localparam int EC = 200;
  localparam int PC = 20;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  sfr_req_t sfr_req;
  logic [7:0] sfr_rdata;
  logic sfr_rvalid;
  logic core_hold;
  logic irq_block;
  int miscompares = 0;
  int total_checks = 0;
  initial forever #2 clock = ~clock;
  data_flash_command_sequencer #(.ERASE_COUNT(EC), .PROGRAM_COUNT(PC)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .core_hold(core_hold),
    .irq_block(irq_block));
  sfr_core_model u_core (.clock(clock), .core_hold(core_hold),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .sfr_req(sfr_req));
  // ==========================================================
  // Compare, report and wait helpers
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bus model stuck behind the hold counts as a mismatch
  always @(posedge clock) begin
    if (u_core.hang) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic run(input logic [7:0] page, input logic load,
      input page_t data, input logic [7:0] cmd, output int n);
    logic same;
    u_core.page_op(page, load, data, cmd);
    n = 0;
    same = 1'b1;
    #1;
    while (core_hold !== 1'b0) begin
      if (irq_block !== core_hold) same = 1'b0;
      if (n == 2000) begin
        miscompares++;
        report_and_stop();
      end
      @(posedge clock);
      #1;
      n++;
    end
    check("irq_block", same, 1'b1);
  endtask
  task automatic read_page(input logic [7:0] page, output page_t d);
    int n;
    logic [7:0] b;
    logic v;
    run(page, 1'b0, '0, CMD_READ, n);
    check("read time", n >= 1 && n <= 12, 1'b1);
    for (int i = 0; i < 4; i++) begin
      u_core.read_reg(ADDR_DATA_FIRST + 8'(i), b, v);
      d[8*i +: 8] = b;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] b;
    logic v;
    u_core.read_reg(ADDR_COMMAND, b, v);
    check("command reset", {v, b}, {1'b1, RESET_COMMAND});
    u_core.read_reg(ADDR_PAGE, b, v);
    check("page reset", {v, b}, {1'b1, RESET_PAGE});
    u_core.read_reg(ADDR_DATA_FIRST, b, v);
    check("data reset", {v, b}, {1'b1, RESET_DATA});
  endtask
  task automatic t_erase_all();
    int n;
    page_t d;
    run(8'h50, 1'b1, 32'h12345678, CMD_PROGRAM, n);
    run(8'h00, 1'b0, '0, CMD_ERASE_ALL, n);
    check("erase all time", n >= EC && n <= EC + 3, 1'b1);
    read_page(8'h00, d);
    check("first page", d, 32'hFFFFFFFF);
    read_page(LAST_PAGE, d);
    check("last page", d, 32'hFFFFFFFF);
    read_page(8'h50, d);
    check("written page erased", d, 32'hFFFFFFFF);
  endtask
  task automatic t_program();
    int n;
    page_t d;
    for (int p = 2; p < 4; p++) begin
      run(8'(p), 1'b1, 32'h44332211 + p, CMD_PROGRAM, n);
      check("program time", n >= PC && n <= PC + 2, 1'b1);
      read_page(8'(p), d);
      check("programmed page", d, 32'h44332211 + p);
    end
  endtask
  task automatic t_verify();
    int n;
    logic [7:0] b;
    logic v;
    run(8'h03, 1'b1, 32'h44332214, CMD_VERIFY, n);
    u_core.read_reg(ADDR_COMMAND, b, v);
    check("verify match", b, 8'h00);
    run(8'h03, 1'b1, 32'h44332215, CMD_VERIFY, n);
    u_core.read_reg(ADDR_COMMAND, b, v);
    check("verify mismatch", b != 8'h00, 1'b1);
  endtask
  task automatic t_modify();
    int n;
    page_t d;
    read_page(8'h03, d);
    u_core.bus_cycle(1'b0, ADDR_DATA_FIRST + 8'h01, 8'hF3);
    run(8'h03, 1'b0, '0, CMD_ERASE_PAGE, n);
    check("erase time", n >= EC && n <= EC + 3, 1'b1);
    run(8'h03, 1'b0, '0, CMD_PROGRAM, n);
    read_page(8'h03, d);
    check("modified page", d, 32'h4433F314);
    read_page(8'h02, d);
    check("neighbour page", d, 32'h44332213);
    run(8'h02, 1'b0, '0, CMD_ERASE_PAGE, n);
    read_page(8'h02, d);
    check("erased page", d, 32'hFFFFFFFF);
    read_page(8'h03, d);
    check("kept page", d, 32'h4433F314);
  endtask
  task automatic t_range();
    int n;
    page_t d;
    run(8'hA0, 1'b1, 32'h00000000, CMD_PROGRAM, n);
    check("out of range time", n < PC, 1'b1);
    read_page(8'h00, d);
    check("page zero kept", d, 32'hFFFFFFFF);
  endtask
  task automatic t_freeze();
    logic [7:0] b;
    logic v;
    u_core.bus_cycle(1'b0, ADDR_DATA_FIRST, 8'h11);
    @(posedge clock);
    clk_en <= 1'b0;
    u_core.bus_cycle(1'b0, ADDR_DATA_FIRST, 8'h5A);
    @(posedge clock);
    clk_en <= 1'b1;
    u_core.read_reg(ADDR_DATA_FIRST, b, v);
    check("frozen write", {v, b}, {1'b1, 8'h11});
  endtask
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_erase_all();
    t_program();
    t_verify();
    t_modify();
    t_range();
    t_freeze();
    report_and_stop();
  end
endmodule // data_flash_command_sequencer_tb
